// >>> rtl/wdwk_pkg.sv
// Package: register map, field layout, reset values and modes of the watchdog
package wdwk_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_WDT_CTRL = 12'h000;
    localparam logic [11:0] OFF_RST_CAUSE = 12'h004;
    localparam logic [11:0] OFF_CLK_CTRL = 12'h008;
    localparam logic [11:0] OFF_WAKE_EN = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;

    // Watchdog control fields
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 3;
    localparam int PER_MSB = 2;
    localparam int PER_LSB = 0;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE = 5'h0a;
    localparam logic [2:0] PER_RESET = 3'h2;
    localparam logic [7:0] WDT_CTRL_RESET = 8'h52;

    // Reset cause flags
    localparam int RC_KEY = 0;
    localparam int RC_LV_CTRL = 1;
    localparam int RC_LV = 2;
    localparam int RC_RSTCTRL = 3;
    localparam int RC_W = 4;

    // Clock control bits
    localparam int CK_SLOW = 0;
    localparam int CK_FAST = 1;

    // Status fields
    localparam int ST_PDF = 0;
    localparam int ST_TO = 1;
    localparam int ST_MODE_LSB = 4;

    // Divided watchdog clock: low-speed oscillator over eight
    localparam int PRESCALE_W = 3;
    localparam int WDT_CNT_W = 18;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;

    // Default software reset delay in pclk cycles
    localparam int SRESET_CYCLES = 64;

    typedef enum logic [2:0] {
        WDWK_RUN = 3'b000,
        WDWK_SLEEP = 3'b001,
        WDWK_IDLE_SLOW_ONLY = 3'b010,
        WDWK_IDLE_BOTH_CLOCKS = 3'b011,
        WDWK_IDLE_FAST_ONLY = 3'b100
    } wdwk_mode_t;

    // Log2 of the overflow length in divided ticks for each period code
    function automatic logic [4:0] wdwk_period_log2(input logic [2:0] code);
        logic [4:0] r;
        r = 5'h08;
        case (code)
            3'h0: r = 5'h08;
            3'h1: r = 5'h0a;
            3'h2: r = 5'h0c;
            3'h3: r = 5'h0e;
            3'h4: r = 5'h0f;
            3'h5: r = 5'h10;
            3'h6: r = 5'h11;
            3'h7: r = 5'h12;
            default: r = 5'h08;
        endcase
        return r;
    endfunction
endpackage

// >>> rtl/wdwk_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module wdwk_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // Both stages reset to each pin's idle level, so no false edge follows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> rtl/wdwk_top.sv
// Watchdog timer with power-down entry and wake-up control, APB slave
`timescale 1ns/1ns
// Operation
// - Halt, fast keep only: fast-only idle
// - Halt sets power-down flag, clears timeout
// - Halt clears counter; runs only if enabled
// - Power-down keeps registers and state unchanged
// - Wake on reset, port edge, interrupt, overflow
// - Reset wake full; overflow resets PC/SP
// - Flag cleared by clear instruction, set by halt
// - Per-pin wake enable; falling edge resumes
// - Blocked interrupt resumes, stays pending
// - Interrupt pending at entry cannot wake
// - Counter clocked by slow oscillator over eight
// - Period code selects overflow length
// - Key enables, disables, else delayed reset
// - Reset: key enabled, period code 010
// - Bad key sets flag; software clears
// - Running overflow resets device, sets timeout
// - Four events clear the watchdog counter
// - Four cause flags, upper bits zero
// - Halt, no keep bits: sleep mode
// - Halt, slow keep only: slow-only idle
// - Halt, both keep bits: both-clocks idle
module wdwk_top #(
    parameter int PORT_W = 8,
    parameter int IRQ_W = 4,
    parameter int SRESET_CYCLES = wdwk_pkg::SRESET_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_speed_rc_osc,
    input wire logic ext_reset_n,
    input wire logic reset_pin_select,
    input wire logic [PORT_W-1:0] port_pins,
    input wire logic halt_instruction,
    input wire logic clear_watchdog_instruction,
    input wire logic [IRQ_W-1:0] irq_request,
    input wire logic [IRQ_W-1:0] irq_enable,
    input wire logic stack_full,
    input wire logic [2:0] other_cause_set,
    output logic power_down_flag,
    output logic watchdog_timeout_flag,
    output logic fast_clock_run,
    output logic slow_clock_run,
    output logic cpu_halted,
    output logic system_reset,
    output logic pc_sp_reset,
    output logic wake_resume,
    output logic irq_response
);
    localparam int SYNC_W = PORT_W + 2;
    localparam int DLY_W = $clog2(SRESET_CYCLES + 1);

    wdwk_pkg::wdwk_mode_t mode;
    logic [7:0] wdt_ctrl;
    logic [1:0] clk_ctrl;
    logic [PORT_W-1:0] port_wake_enable;
    logic [wdwk_pkg::RC_W-1:0] reset_cause_flags;
    logic [SYNC_W-1:0] sync_q;
    logic [PORT_W-1:0] port_s;
    logic [PORT_W-1:0] port_d;
    logic low_speed_rc_osc_s;
    logic low_speed_rc_osc_d;
    logic ext_rst_s;
    logic [wdwk_pkg::PRESCALE_W-1:0] prescale;
    logic [wdwk_pkg::WDT_CNT_W-1:0] wdt_count;
    logic [wdwk_pkg::WDT_CNT_W-1:0] wdt_limit;
    logic [IRQ_W-1:0] irq_blocked;
    logic [DLY_W-1:0] sreset_count;
    logic sreset_pending;
    logic wr;
    logic rd_setup;
    logic [4:0] key;
    logic [4:0] next_key;
    logic wdt_enabled;
    logic key_write_bad;
    logic div_tick;
    logic overflow;
    logic down;
    logic ext_reset_low;
    logic port_wake;
    logic [IRQ_W-1:0] irq_wake_vec;
    logic irq_wake;
    logic irq_serviceable;
    logic halt_go;
    logic [18:0] limit_full;

    wdwk_sync #(
        .W(SYNC_W),
        .RST_VAL({{PORT_W{1'b1}}, 2'b10})
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({port_pins, ext_reset_n, low_speed_rc_osc}),
        .q(sync_q)
    );

    assign low_speed_rc_osc_s = sync_q[0];
    assign ext_rst_s = sync_q[1];
    assign port_s = sync_q[SYNC_W-1:2];

    // Access phase write; setup cycle is used to stage the read answer
    assign wr = psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable;
    assign key = wdt_ctrl[wdwk_pkg::KEY_MSB:wdwk_pkg::KEY_LSB];
    assign next_key = pwdata[wdwk_pkg::KEY_MSB:wdwk_pkg::KEY_LSB];
    assign wdt_enabled = (key == wdwk_pkg::KEY_ENABLE);
    assign key_write_bad = wr && (paddr == wdwk_pkg::OFF_WDT_CTRL) &&
        (next_key != wdwk_pkg::KEY_ENABLE) &&
        (next_key != wdwk_pkg::KEY_DISABLE);
    assign down = (mode != wdwk_pkg::WDWK_RUN);
    assign halt_go = halt_instruction && !down;
    assign ext_reset_low = reset_pin_select && !ext_rst_s;

    // Edge of the synchronised oscillator; the first stage is never read
    assign div_tick = low_speed_rc_osc_s && !low_speed_rc_osc_d &&
        (prescale == wdwk_pkg::PRESCALE_LAST);
    assign limit_full = (19'h1 << wdwk_pkg::wdwk_period_log2(
        wdt_ctrl[wdwk_pkg::PER_MSB:wdwk_pkg::PER_LSB])) - 19'h1;
    assign wdt_limit = limit_full[wdwk_pkg::WDT_CNT_W-1:0];
    assign overflow = wdt_enabled && div_tick &&
        (wdt_count == wdt_limit);

    assign port_wake = |(port_wake_enable & port_d & ~port_s);
    assign irq_wake_vec = irq_request & ~irq_blocked;
    assign irq_wake = |irq_wake_vec;
    assign irq_serviceable = |(irq_wake_vec & irq_enable) && !stack_full;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_speed_rc_osc_d <= 1'b0;
            port_d <= '1;
        end else begin
            low_speed_rc_osc_d <= low_speed_rc_osc_s;
            port_d <= port_s;
        end
    end

    // Divide-by-eight prescaler, cleared together with the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (halt_go || clear_watchdog_instruction ||
                     key_write_bad || ext_reset_low) begin
            prescale <= '0;
        end else if (wdt_enabled && low_speed_rc_osc_s && !low_speed_rc_osc_d) begin
            prescale <= prescale + 3'h1;
        end
    end

    // Watchdog counter; software clears it by the clear instruction, by halt or by a bad key write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_count <= '0;
        end else if (key_write_bad || clear_watchdog_instruction ||
                     halt_go || ext_reset_low) begin
            wdt_count <= '0;
        end else if (overflow) begin
            wdt_count <= '0;
        end else if (wdt_enabled && div_tick) begin
            wdt_count <= wdt_count + 18'h1;
        end
    end

    // Operating mode; registers and ports are left alone while halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= wdwk_pkg::WDWK_RUN;
        end else begin
            case (mode)
                wdwk_pkg::WDWK_RUN: begin
                    if (halt_instruction) begin
                        case (clk_ctrl)
                            2'b00: mode <= wdwk_pkg::WDWK_SLEEP;
                            2'b01: mode <= wdwk_pkg::WDWK_IDLE_SLOW_ONLY;
                            2'b11: mode <= wdwk_pkg::WDWK_IDLE_BOTH_CLOCKS;
                            2'b10: mode <= wdwk_pkg::WDWK_IDLE_FAST_ONLY;
                            default: mode <= wdwk_pkg::WDWK_SLEEP;
                        endcase
                    end
                end
                wdwk_pkg::WDWK_SLEEP,
                wdwk_pkg::WDWK_IDLE_SLOW_ONLY,
                wdwk_pkg::WDWK_IDLE_BOTH_CLOCKS,
                wdwk_pkg::WDWK_IDLE_FAST_ONLY: begin
                    if (ext_reset_low || port_wake || irq_wake ||
                        overflow) begin
                        mode <= wdwk_pkg::WDWK_RUN;
                    end
                end
                default: mode <= wdwk_pkg::WDWK_RUN;
            endcase
        end
    end

    // Requests already raised at entry cannot wake the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_blocked <= '0;
        end else if (halt_go) begin
            irq_blocked <= irq_request;
        end else if (!down) begin
            irq_blocked <= '0;
        end
    end

    // Power-down and timeout flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else begin
            if (halt_go) begin
                power_down_flag <= 1'b1;
            end else if (clear_watchdog_instruction) begin
                power_down_flag <= 1'b0;
            end
            if (overflow) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (halt_go) begin
                watchdog_timeout_flag <= 1'b0;
            end
        end
    end

    // Wake and reset actions towards the core, one-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset <= 1'b0;
            pc_sp_reset <= 1'b0;
            wake_resume <= 1'b0;
            irq_response <= 1'b0;
        end else begin
            system_reset <= (overflow && !down) ||
                (down && ext_reset_low) ||
                (sreset_pending &&
                 sreset_count == DLY_W'(SRESET_CYCLES));
            pc_sp_reset <= down && overflow && !ext_reset_low;
            wake_resume <= down && !ext_reset_low && !overflow &&
                (port_wake || (irq_wake && !irq_serviceable));
            irq_response <= down && !ext_reset_low && !overflow &&
                !port_wake && irq_wake && irq_serviceable;
        end
    end

    // Delay between a bad key and the reset it causes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sreset_pending <= 1'b0;
            sreset_count <= '0;
        end else if (key_write_bad) begin
            sreset_pending <= 1'b1;
            sreset_count <= '0;
        end else if (sreset_pending) begin
            if (sreset_count == DLY_W'(SRESET_CYCLES)) begin
                sreset_pending <= 1'b0;
            end else begin
                sreset_count <= sreset_count + DLY_W'(1);
            end
        end
    end

    // Clock keep outputs follow the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_clock_run <= 1'b1;
            slow_clock_run <= 1'b1;
            cpu_halted <= 1'b0;
        end else begin
            cpu_halted <= down;
            fast_clock_run <= !down ||
                mode == wdwk_pkg::WDWK_IDLE_FAST_ONLY ||
                mode == wdwk_pkg::WDWK_IDLE_BOTH_CLOCKS;
            slow_clock_run <= !down ||
                mode == wdwk_pkg::WDWK_IDLE_SLOW_ONLY ||
                mode == wdwk_pkg::WDWK_IDLE_BOTH_CLOCKS;
        end
    end

    // Software registers; halting does not touch them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_ctrl <= wdwk_pkg::WDT_CTRL_RESET;
            clk_ctrl <= '0;
            port_wake_enable <= '0;
        end else if (wr) begin
            case (paddr)
                wdwk_pkg::OFF_WDT_CTRL: wdt_ctrl <= pwdata[7:0];
                wdwk_pkg::OFF_CLK_CTRL: clk_ctrl <= pwdata[1:0];
                wdwk_pkg::OFF_WAKE_EN: port_wake_enable <= pwdata[PORT_W-1:0];
                default: clk_ctrl <= clk_ctrl;
            endcase
        end
    end

    // Cause flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause_flags <= '0;
        end else begin
            reset_cause_flags <= (reset_cause_flags &
                ((wr && paddr == wdwk_pkg::OFF_RST_CAUSE) ?
                 pwdata[wdwk_pkg::RC_W-1:0] : 4'hf)) |
                {other_cause_set, key_write_bad};
        end
    end

    // Zero-wait APB: answer staged in setup, presented in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= rd_setup;
            pslverr <= 1'b0;
            prdata <= '0;
            if (rd_setup) begin
                case (paddr)
                    wdwk_pkg::OFF_WDT_CTRL: prdata <= {24'h0, wdt_ctrl};
                    wdwk_pkg::OFF_RST_CAUSE:
                        prdata <= {28'h0, reset_cause_flags};
                    wdwk_pkg::OFF_CLK_CTRL: prdata <= {30'h0, clk_ctrl};
                    wdwk_pkg::OFF_WAKE_EN:
                        prdata <= 32'(port_wake_enable);
                    wdwk_pkg::OFF_STATUS:
                        prdata <= {25'h0, mode, 2'h0,
                                   watchdog_timeout_flag, power_down_flag};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

// >>> sim/wdwk_top_sva.sv
// Checker: bus timing and power-down relations at the watchdog ports
`timescale 1ns/1ns
module wdwk_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic halt_instruction,
    input wire logic clear_watchdog_instruction,
    input wire logic power_down_flag,
    input wire logic watchdog_timeout_flag,
    input wire logic cpu_halted,
    input wire logic system_reset,
    input wire logic pc_sp_reset,
    input wire logic wake_resume,
    input wire logic irq_response
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_halt_sets_flags: assert property (
        halt_instruction && !cpu_halted |=> power_down_flag
        && !watchdog_timeout_flag) else $error("halt flags wrong");
    a_halt_enters_mode: assert property (
        halt_instruction && !cpu_halted |=> ##1 cpu_halted)
        else $error("halt not entered");
    a_clear_drops_pdf: assert property (
        clear_watchdog_instruction && !halt_instruction |=> !power_down_flag)
        else $error("power-down flag kept after clear");
    a_timeout_has_reset: assert property (
        $rose(watchdog_timeout_flag) |-> system_reset || pc_sp_reset)
        else $error("timeout without reset");
    a_sleep_overflow: assert property (
        pc_sp_reset |-> watchdog_timeout_flag && power_down_flag
        && !system_reset) else $error("sleep overflow flags wrong");
    a_wake_leaves_halt: assert property (
        wake_resume || irq_response |=> !cpu_halted)
        else $error("still halted after wake");
    a_reset_one_pulse: assert property (system_reset |=> !system_reset)
        else $error("reset pulse too long");
    c_halt: cover property (halt_instruction ##2 cpu_halted);
    c_sleep_overflow: cover property (pc_sp_reset);
    c_irq_wake: cover property (irq_response);
    c_port_wake: cover property (wake_resume);
endmodule

bind wdwk_top wdwk_top_sva i_sva (.*);

// >>> sim/wdwk_top_test.sv
// Testbench: watchdog, power-down and wake-up scenarios over the bus
`timescale 1ns/1ns
module wdwk_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic ext_reset_n = 1'b1;
    logic reset_pin_select = 1'b0;
    logic [7:0] port_pins = 8'hff;
    logic halt_instruction = 1'b0;
    logic clear_watchdog_instruction = 1'b0;
    logic [3:0] irq_request = 4'h0;
    logic [3:0] irq_enable = 4'h0;
    logic stack_full = 1'b0;
    logic [2:0] other_cause_set = 3'h0;
    logic power_down_flag, watchdog_timeout_flag, fast_clock_run;
    logic slow_clock_run, cpu_halted, system_reset, pc_sp_reset;
    logic wake_resume, irq_response;
    logic [1:0] div = 2'h0;
    wire logic low_speed_rc_osc;
    logic [32:0] expq[$];
    logic [2:0] mode_of [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 32'h2966;
    int n, k, p;

    // Slow oscillator sped up to one rising edge every four cycles
    assign low_speed_rc_osc = div[1];
    wdwk_top #(.SRESET_CYCLES(4)) i_dut (.*);

    initial begin
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        div <= div + 2'h1;
    end

    task summarize;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task cmp_word(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 50000) begin
            err_count++;
            $display("mismatch at %0t: run too long", $time);
            summarize();
        end
    end

    // Read results are matched against notes in issue order
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            cmp_word({pslverr, prdata}, expq.pop_front());
    end

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask

    task pulse(input logic halt);
        @(posedge pclk);
        halt_instruction <= halt;
        clear_watchdog_instruction <= !halt;
        @(posedge pclk);
        halt_instruction <= 1'b0;
        clear_watchdog_instruction <= 1'b0;
    endtask

    function logic sig(input int s);
        case (s)
            0: return system_reset;
            1: return pc_sp_reset;
            2: return wake_resume;
            3: return irq_response;
            default: return wake_resume | irq_response;
        endcase
    endfunction

    // Counts edges until the chosen pulse shows, stopping at lim
    task wait_sig(input int s, input int lim);
        n = 0;
        while (sig(s) !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(wdwk_pkg::OFF_WDT_CTRL, 33'h52);
        rd(wdwk_pkg::OFF_STATUS, 33'h0);
        rd(12'h014, {1'b1, 32'h0});
        apb(12'h014, 1'b1, 32'hff);
        $display("done: reset values");
        apb(wdwk_pkg::OFF_WDT_CTRL, 1'b1, 32'h50);
        pulse(1'b0);
        wait_sig(0, 6000);
        cmp_bit(n == 6000, 1'b1, "early overflow");
        pulse(1'b0);
        wait_sig(0, 9000);
        cmp_bit(n > 8170 && n < 8215, 1'b1, "overflow time");
        cmp_bit(watchdog_timeout_flag, 1'b1, "timeout flag");
        apb(wdwk_pkg::OFF_WDT_CTRL, 1'b1, 32'ha8);
        wait_sig(0, 9000);
        cmp_bit(n == 9000, 1'b1, "disabled dog fired");
        $display("done: overflow and key");
        apb(wdwk_pkg::OFF_WDT_CTRL, 1'b1, 32'h00);
        wait_sig(0, 40);
        apb(wdwk_pkg::OFF_WDT_CTRL, 1'b1, 32'h57);
        cmp_bit(n >= 3 && n <= 7, 1'b1, "bad key delay");
        rd(wdwk_pkg::OFF_RST_CAUSE, 33'h1);
        @(posedge pclk);
        other_cause_set <= 3'h7;
        @(posedge pclk);
        other_cause_set <= 3'h0;
        rd(wdwk_pkg::OFF_RST_CAUSE, 33'h0f);
        apb(wdwk_pkg::OFF_RST_CAUSE, 1'b1, 32'h0e);
        rd(wdwk_pkg::OFF_RST_CAUSE, 33'h0e);
        apb(wdwk_pkg::OFF_RST_CAUSE, 1'b1, 32'hf0);
        rd(wdwk_pkg::OFF_RST_CAUSE, 33'h0);
        $display("done: cause flags");
        for (k = 0; k < 4; k++) begin
            p = $random(seed) & 7;
            apb(wdwk_pkg::OFF_CLK_CTRL, 1'b1, 32'(k));
            apb(wdwk_pkg::OFF_WAKE_EN, 1'b1, 32'h1 << p);
            pulse(1'b1);
            rd(wdwk_pkg::OFF_STATUS, {26'h0, mode_of[k], 4'h1});
            cmp_bit(fast_clock_run, k[1], "fast clock");
            cmp_bit(slow_clock_run, k[0], "slow clock");
            cmp_bit(cpu_halted, 1'b1, "not halted");
            cmp_bit(power_down_flag, 1'b1, "pdf pin");
            rd(wdwk_pkg::OFF_WDT_CTRL, 33'h57);
            @(posedge pclk);
            port_pins <= ~(8'h1 << (p ^ 1));
            wait_sig(2, 12);
            cmp_bit(n == 12, 1'b1, "disabled pin woke");
            port_pins <= ~(8'h1 << p);
            wait_sig(2, 12);
            cmp_bit(n < 12, 1'b1, "no pin wake");
            port_pins <= 8'hff;
        end
        pulse(1'b0);
        rd(wdwk_pkg::OFF_STATUS, 33'h0);
        cmp_bit(power_down_flag, 1'b0, "pdf pin kept");
        $display("done: halt modes");
        for (k = 0; k < 3; k++) begin
            irq_enable <= {3'h0, k != 2};
            stack_full <= (k == 1);
            pulse(1'b1);
            repeat (2) @(posedge pclk);
            irq_request <= 4'h1;
            wait_sig(k == 0 ? 3 : 2, 12);
            cmp_bit(n < 12, 1'b1, "irq wake");
            irq_request <= 4'h0;
        end
        @(posedge pclk);
        irq_request <= 4'h2;
        pulse(1'b1);
        wait_sig(4, 20);
        cmp_bit(n == 20, 1'b1, "stale irq woke");
        reset_pin_select <= 1'b1;
        ext_reset_n <= 1'b0;
        wait_sig(0, 12);
        cmp_bit(n < 12, 1'b1, "no reset wake");
        ext_reset_n <= 1'b1;
        reset_pin_select <= 1'b0;
        irq_request <= 4'h0;
        $display("done: interrupt and reset wake");
        apb(wdwk_pkg::OFF_WDT_CTRL, 1'b1, 32'h50);
        pulse(1'b1);
        wait_sig(1, 9000);
        cmp_bit(n < 9000 && system_reset === 1'b0, 1'b1, "sleep dog");
        apb(wdwk_pkg::OFF_WDT_CTRL, 1'b1, 32'ha8);
        rd(wdwk_pkg::OFF_STATUS, 33'h3);
        $display("done: sleep overflow");
        summarize();
    end
endmodule
